//--- pfcs_map.svh
// constant map for the pfc supervisor logic: offsets, fields, resets, timing
// assumes a 100 MHz pclk and a 12-bit apb byte address
`ifndef PFCS_MAP_SVH
`define PFCS_MAP_SVH
// ==========================================================
// register map
`define PFCS_CTRL_OFS      12'h000
`define PFCS_STATUS_OFS    12'h004
`define PFCS_CTRL_RUN_BIT  0
`define PFCS_CTRL_RST      32'h0000_0001
// ==========================================================
// status field positions
`define PFCS_ST_GATE       0
`define PFCS_ST_OSTRESS    1
`define PFCS_ST_PGOOD      2
`define PFCS_ST_HILINE     3
`define PFCS_ST_OFF        4
`define PFCS_ST_BROWNOUT   5
`define PFCS_ST_ENABLED    6
`define PFCS_ST_BLOCK      7
// ==========================================================
// timing
`define PFCS_CLK_MHZ       100
`define PFCS_T_OSTRESS_US  1000
`define PFCS_T_WDOG_US     200
`define PFCS_T_BO_MS       54
`define PFCS_T_LH_US       300
`define PFCS_T_HL_MS       54
`define PFCS_OSTRESS_CYC   (`PFCS_T_OSTRESS_US * `PFCS_CLK_MHZ)
`define PFCS_WDOG_CYC      (`PFCS_T_WDOG_US * `PFCS_CLK_MHZ)
`define PFCS_BO_CYC        (`PFCS_T_BO_MS * 1000 * `PFCS_CLK_MHZ)
`define PFCS_LH_CYC        (`PFCS_T_LH_US * `PFCS_CLK_MHZ)
`define PFCS_HL_CYC        (`PFCS_T_HL_MS * 1000 * `PFCS_CLK_MHZ)
`define PFCS_VALLEYS       4'h8
`endif

//--- pfcs_pkg.sv
// types for the pfc supervisor logic
// assumes pfcs_map.svh holds all numeric constants
package pfcs_pkg;
	// ==========================================================
	// comparator outputs, all asynchronous to pclk
	typedef struct packed {
		logic demag_arm;        // cs/zcd above demag_arm_level
		logic demag_below_trig; // cs/zcd below lower trigger level
		logic on_time_done;     // on_time_control ramp reached
		logic line_bo_start;    // line above brownout_start_level
		logic line_bo_stop;     // line above brownout_stop_level
		logic line_hl_sel;      // line above high_line_select_level
		logic line_ll_sel;      // line above low_line_select_level
		logic valley;           // valley detector pulse
		logic supply_on;        // supply at turn-on level
		logic supply_above_off; // supply above off level
		logic bulk_undervoltage;
		logic reg_reached;      // error_amplifier current at or below zero
		logic feedback_uv;
		logic fault_pin;
		logic open_fb;
		logic thermal_sd;
		logic line_removed;
		logic skip_mode;
		logic latch_mode;
		logic output_undervoltage_detect;
		logic ovp_latch_in;
	} pfcs_cmp_t;
	// ==========================================================
	// gate drive states, gray along off -> on -> demag -> on
	typedef enum logic [1:0] {
		PFCS_OFF     = 2'b00,
		PFCS_ON      = 2'b01,
		PFCS_DEMAG   = 2'b11,
		PFCS_OSTRESS = 2'b10
	} pfcs_drv_st_t;
endpackage : pfcs_pkg

//--- pfcs_top.sv
// supervisory logic of a boost pfc controller with an apb register slave
// assumes comparator levels arrive asynchronously; single pclk domain
//
// Functional notes
// RL1: demag arm during conduction ends pulse, sets overstress latch and flag.
// RL2: after overstress hold drive off 1 ms before next pulse.
// RL3: regulation good low in start-up, faults, low supply, line removal.
// RL4: regulation good rises when regulation reached, stays high until a fault.
// RL5: regulation good held low while bulk undervoltage is active.
// RL6: enable only when line above brownout start and supply at turn-on.
// RL7: line below brownout stop starts 54 ms timer; expiry disables operation.
// RL8: line range comes up in low-line mode.
// RL9: go high-line after line above select level longer than 300 us.
// RL10: after return to low-line block high-line until 8 valleys counted.
// RL11: high-line runs 54 ms timer below low select, reset above, expiry drops.
// RL12: high-line selects four-times steeper modulation ramp.
// RL13: shutdown holds the gate driver sinking, output low.
// RL14: off mode on supply lockout, thermal, brownout, skip, bulk uv, latch.
// RL15: off mode keeps detectors running and supply regulated between levels.
// RL16: off mode grounds loop control, regulation good and on-time output.
// RL17: demag asserts above arm level; its end is below trigger level.
// RL18: with no demag event a watchdog of 200 us starts next pulse.
// RL19: comparators synchronised before use; timers are cycle counters.
// RL20: brownout timer restarts from zero when line recovers above stop.
//
// Chosen here: the address map and register access over APB.
`include "pfcs_map.svh"
module pfcs_top #(
	parameter logic [22:0] OSTRESS_CYC = 23'(`PFCS_OSTRESS_CYC),
	parameter logic [22:0] WDOG_CYC    = 23'(`PFCS_WDOG_CYC),
	parameter logic [22:0] BO_CYC      = 23'(`PFCS_BO_CYC),
	parameter logic [22:0] LH_CYC      = 23'(`PFCS_LH_CYC),
	parameter logic [22:0] HL_CYC      = 23'(`PFCS_HL_CYC)
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire pfcs_pkg::pfcs_cmp_t cmp_in,
	output logic                  gate_drive,
	output logic                  driver_sink,
	output logic                  overstress_flag,
	output logic                  regulation_good_out,
	output logic                  ramp_steep_x4,
	output logic                  off_mode,
	output logic                  loop_ctrl_ground,
	output logic                  on_time_ground,
	output logic                  supply_charge_en
);
	import pfcs_pkg::*;

	// saturating count step shared by every timer
	function automatic logic [22:0] tick(input logic [22:0] c);
		tick = (c == 23'h7FFFFF) ? c : c + 23'h000001;
	endfunction : tick

	// ==========================================================
	// input synchroniser
	localparam int NCMP = $bits(pfcs_cmp_t);
	logic [NCMP-1:0] s1_q, s2_q, s3_q, filt_q;
	pfcs_cmp_t       f;
	assign f = pfcs_cmp_t'(filt_q);

	// three stages; a bit moves only when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			filt_q <= '0;
		end else begin
			s1_q   <= cmp_in; // RL19
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q); // RL19
		end
	end

	// ==========================================================
	// apb slave
	logic        run_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q;
	logic        acc, hit;
	logic [31:0] status;
	assign acc = psel && penable && !pready_q;
	assign hit = (paddr == `PFCS_CTRL_OFS) || (paddr == `PFCS_STATUS_OFS);

	// one wait state: answer in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc;
			pslverr_q <= acc && !hit;
			if (acc && !pwrite) begin
				prdata_q <= (paddr == `PFCS_CTRL_OFS) ? {31'h0, run_q} :
					(paddr == `PFCS_STATUS_OFS) ? status : 32'h0000_0000;
			end
		end
	end

	// software run enable; writes land at the completing edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'(`PFCS_CTRL_RST);
		end else if (psel && penable && pready_q && pwrite && paddr == `PFCS_CTRL_OFS) begin
			run_q <= pwdata[`PFCS_CTRL_RUN_BIT];
		end
	end

	// ==========================================================
	// brownout enable
	logic        enabled_q, brownout_q;
	logic [22:0] bo_cnt_q;

	// timer runs only while line sits below stop level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bo_cnt_q <= '0;
		end else if (f.line_bo_stop) begin
			bo_cnt_q <= '0; // RL20
		end else begin
			bo_cnt_q <= tick(bo_cnt_q); // RL7
		end
	end

	// brownout stays flagged until the line climbs past start level again with supply at turn-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enabled_q  <= 1'b0;
			brownout_q <= 1'b0;
		end else if (!f.line_bo_stop && bo_cnt_q >= BO_CYC - 23'h000001) begin
			enabled_q  <= 1'b0; // RL7
			brownout_q <= 1'b1;
		end else if (f.line_bo_start && f.supply_on) begin
			enabled_q  <= 1'b1; // RL6
			brownout_q <= 1'b0;
		end
	end

	// ==========================================================
	// off mode and shutdown
	logic off_now, pg_fault;
	// detectors above stay live in off mode; only the drive, loop, on-time and regulation good paths are gated
	assign off_now = !f.supply_above_off || f.thermal_sd || brownout_q || f.skip_mode
		|| f.bulk_undervoltage || f.latch_mode || !enabled_q || !run_q; // RL14
	assign pg_fault = off_now || f.feedback_uv || f.fault_pin || f.open_fb
		|| f.line_removed; // RL3

	logic off_q, sink_q, lgnd_q, tgnd_q, chg_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_q  <= 1'b1;
			sink_q <= 1'b1;
			lgnd_q <= 1'b1;
			tgnd_q <= 1'b1;
		end else begin
			off_q  <= off_now;
			sink_q <= off_now; // RL13
			lgnd_q <= off_now; // RL16
			tgnd_q <= off_now; // RL16
		end
	end

	// supply hysteresis keeps running whatever the mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_q <= 1'b1;
		end else if (!f.supply_above_off) begin
			chg_q <= 1'b1; // RL15
		end else if (f.supply_on) begin
			chg_q <= 1'b0; // RL15
		end
	end

	// ==========================================================
	// regulation good
	logic pg_q;
	// once set it holds until a fault, not on regulation loss
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_q <= 1'b0;
		end else if (pg_fault) begin
			pg_q <= 1'b0; // RL3
		end else if (f.bulk_undervoltage) begin
			pg_q <= 1'b0; // RL5
		end else if (f.reg_reached) begin
			pg_q <= 1'b1; // RL4
		end
	end

	// ==========================================================
	// line range detector
	logic        hl_q, block_q, valley_d1_q;
	logic [22:0] lh_cnt_q, hl_cnt_q;
	logic [3:0]  valley_cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lh_cnt_q <= '0;
			hl_cnt_q <= '0;
		end else begin
			lh_cnt_q <= f.line_hl_sel ? tick(lh_cnt_q) : '0; // RL9
			hl_cnt_q <= (hl_q && !f.line_ll_sel) ? tick(hl_cnt_q) : '0; // RL11
		end
	end

	// noise guard: a drop to low line needs fresh valleys before going high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hl_q         <= 1'b0; // RL8
			block_q      <= 1'b0;
			valley_cnt_q <= 4'h0;
			valley_d1_q  <= 1'b0;
		end else begin
			valley_d1_q <= f.valley;
			if (hl_q && hl_cnt_q >= HL_CYC - 23'h000001) begin
				hl_q         <= 1'b0; // RL11
				block_q      <= 1'b1; // RL10
				valley_cnt_q <= 4'h0;
			end else if (!hl_q && block_q) begin
				if (f.valley && !valley_d1_q) begin
					valley_cnt_q <= valley_cnt_q + 4'h1;
				end
				if (valley_cnt_q >= `PFCS_VALLEYS) begin
					block_q <= 1'b0; // RL10
				end
			end else if (!hl_q && lh_cnt_q >= LH_CYC) begin
				hl_q <= 1'b1; // RL9
			end
		end
	end

	logic ramp_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_q <= 1'b0;
		end else begin
			ramp_q <= hl_q; // RL12
		end
	end

	// ==========================================================
	// gate drive sequencer
	pfcs_drv_st_t st_q, st_d;
	logic [22:0]  tmr_q;
	logic         seen_q, ostress_q, gate_q;

	always_comb begin
		st_d = st_q;
		case (st_q)
			PFCS_OFF:     st_d = PFCS_ON;
			PFCS_ON: begin
				if (f.demag_arm) begin
					st_d = PFCS_OSTRESS; // RL1
				end else if (f.on_time_done) begin
					st_d = PFCS_DEMAG;
				end
			end
			PFCS_DEMAG: begin
				if (seen_q && f.demag_below_trig) begin
					st_d = PFCS_ON; // RL17
				end else if (!seen_q && tmr_q >= WDOG_CYC - 23'h000001) begin
					st_d = PFCS_ON; // RL18
				end
			end
			PFCS_OSTRESS: begin
				if (tmr_q >= OSTRESS_CYC - 23'h000001) begin
					st_d = PFCS_ON; // RL2
				end
			end
			default:      st_d = PFCS_OFF;
		endcase
		if (off_now) begin
			st_d = PFCS_OFF; // RL13
		end
	end

	// shared timer restarts on every state change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= PFCS_OFF;
			tmr_q  <= '0;
			seen_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			tmr_q  <= (st_d != st_q) ? '0 : tick(tmr_q);
			seen_q <= (st_d == PFCS_DEMAG) && (seen_q || f.demag_arm); // RL17
			gate_q <= (st_d == PFCS_ON); // RL1
		end
	end

	// overstress flag lives for the whole long off time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ostress_q <= 1'b0;
		end else begin
			ostress_q <= (st_d == PFCS_OSTRESS); // RL1
		end
	end

	// ==========================================================
	// status and outputs
	always_comb begin
		status = 32'h0000_0000;
		status[`PFCS_ST_GATE]     = gate_q;
		status[`PFCS_ST_OSTRESS]  = ostress_q;
		status[`PFCS_ST_PGOOD]    = pg_q;
		status[`PFCS_ST_HILINE]   = hl_q;
		status[`PFCS_ST_OFF]      = off_q;
		status[`PFCS_ST_BROWNOUT] = brownout_q;
		status[`PFCS_ST_ENABLED]  = enabled_q;
		status[`PFCS_ST_BLOCK]    = block_q;
	end

	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign gate_drive          = gate_q;
	assign driver_sink         = sink_q;
	assign overstress_flag     = ostress_q;
	assign regulation_good_out = pg_q;
	assign ramp_steep_x4       = ramp_q;
	assign off_mode            = off_q;
	assign loop_ctrl_ground    = lgnd_q;
	assign on_time_ground      = tgnd_q;
	assign supply_charge_en    = chg_q;

	// ==========================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// off mode outranks overstress, so only a live pulse is held to the latch
	a_ostress_entry: assert property (st_q == PFCS_ON && f.demag_arm && !off_now
		|=> !gate_q && ostress_q) // RL1
		else $error("overstress did not end the pulse");
	a_ostress_hold: assert property ($rose(ostress_q) |-> !gate_q [*8]) // RL2
		else $error("drive resumed during overstress off time");
	a_pg_fault_low: assert property (pg_fault |=> !pg_q) // RL3
		else $error("regulation good high during a fault");
	a_pg_rise: assert property (!pg_fault && !f.bulk_undervoltage && f.reg_reached |=> pg_q) // RL4
		else $error("regulation good did not rise");
	a_pg_buv: assert property (f.bulk_undervoltage |=> !pg_q) // RL5
		else $error("regulation good high under bulk undervoltage");
	a_enable_cause: assert property ($rose(enabled_q) |-> $past(f.line_bo_start) && $past(f.supply_on)) // RL6
		else $error("enabled without brownout start and supply on");
	a_bo_expire: assert property (!f.line_bo_stop && bo_cnt_q == BO_CYC - 23'h000001 |=> !enabled_q) // RL7
		else $error("brownout expiry did not disable");
	a_bo_restart: assert property (f.line_bo_stop |=> bo_cnt_q == 23'h0) // RL20
		else $error("brownout timer not restarted");
	a_hl_block: assert property (block_q && !hl_q |=> !hl_q) // RL10
		else $error("high line taken while blocked");
	a_ramp_follow: assert property (hl_q != ramp_q |=> ramp_q == $past(hl_q)) // RL12
		else $error("ramp select lags line mode");
	a_off_sink: assert property (off_now |=> sink_q && !gate_q && lgnd_q && tgnd_q && !pg_q) // RL16
		else $error("off mode outputs not held");
	a_watchdog_fire: assert property (st_q == PFCS_DEMAG && !seen_q && !off_now
		&& tmr_q == WDOG_CYC - 23'h000001 |=> gate_q) // RL18
		else $error("watchdog did not restart drive");

	c_overstress: cover property ($rose(ostress_q));
	c_high_line:  cover property ($rose(hl_q));
	c_brownout:   cover property ($rose(brownout_q));
	c_pg_good:    cover property ($rose(pg_q));
endmodule : pfcs_top

//--- pfcs_stage_model.sv
// behavioural boost stage: answers the gate with on-time, demag arm and trigger levels
// assumes gate_drive comes from pfcs_top; levels change just after a rising pclk edge
module pfcs_stage_model #(
	parameter int ON_LEN  = 6,
	parameter int DEM_LEN = 6
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic gate_drive,
	input  wire logic short_diode,
	input  wire logic no_demag,
	output logic      demag_arm,
	output logic      demag_below_trig,
	output logic      on_time_done
);
	int on_q;
	int off_q;
	// ==========================================================
	// conduction and demag phase counters, off count saturates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_q  <= 0;
			off_q <= DEM_LEN;
		end else if (gate_drive) begin
			on_q  <= on_q + 1;
			off_q <= 0;
		end else begin
			on_q <= 0;
			if (off_q < DEM_LEN) begin
				off_q <= off_q + 1;
			end
		end
	end
	// ==========================================================
	// sensed levels; a shorted diode arms demag during conduction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			demag_arm        <= 1'b0;
			demag_below_trig <= 1'b1;
			on_time_done     <= 1'b0;
		end else begin
			on_time_done     <= gate_drive && on_q >= ON_LEN;
			demag_arm        <= gate_drive ? short_diode : (!no_demag && off_q < DEM_LEN);
			demag_below_trig <= !gate_drive && off_q >= DEM_LEN;
		end
	end
endmodule : pfcs_stage_model

//--- tb_top.sv
// self-checking bench for the pfc supervisor: apb tasks and comparator sequences
// assumes shortened timer parameters and the stage model on the demag inputs
`include "pfcs_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pfcs_pkg::*;
	localparam int OST = 20;
	localparam int WDG = 60;
	localparam int BO  = 40;
	localparam int LH  = 10;
	localparam int HL  = 40;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	pfcs_cmp_t   cmp, cmp_w;
	logic        gate_drive, driver_sink, overstress_flag, regulation_good_out, ramp_steep_x4;
	logic        off_mode, loop_ctrl_ground, on_time_ground, supply_charge_en;
	logic        short_diode, no_demag, m_arm, m_below, m_done;
	int          mismatches, comparisons, n, i;

	pfcs_top #(.OSTRESS_CYC(23'(OST)), .WDOG_CYC(23'(WDG)), .BO_CYC(23'(BO)),
		.LH_CYC(23'(LH)), .HL_CYC(23'(HL))) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_in(cmp_w),
		.gate_drive(gate_drive), .driver_sink(driver_sink), .overstress_flag(overstress_flag),
		.regulation_good_out(regulation_good_out), .ramp_steep_x4(ramp_steep_x4),
		.off_mode(off_mode), .loop_ctrl_ground(loop_ctrl_ground),
		.on_time_ground(on_time_ground), .supply_charge_en(supply_charge_en));
	pfcs_stage_model u_stage (.pclk(pclk), .presetn(presetn), .gate_drive(gate_drive),
		.short_diode(short_diode), .no_demag(no_demag), .demag_arm(m_arm),
		.demag_below_trig(m_below), .on_time_done(m_done));

	// model owns the demag arm, demag trigger and on-time comparator lines
	always_comb begin
		cmp_w                  = cmp;
		cmp_w.demag_arm        = m_arm;
		cmp_w.demag_below_trig = m_below;
		cmp_w.on_time_done     = m_done;
	end
	// ==========================================================
	// shared tasks
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// apb transfer; waits for pready, no fixed latency assumed
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		check("apb_ready", pready, 1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_lvl(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 500) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_lvl
	task set_fault(input int f, input logic v);
		case (f)
			0: cmp.bulk_undervoltage <= v;
			1: cmp.feedback_uv <= v;
			2: cmp.fault_pin <= v;
			3: cmp.open_fb <= v;
			4: cmp.line_removed <= v;
			5: cmp.thermal_sd <= v;
			6: cmp.skip_mode <= v;
			7: cmp.latch_mode <= v;
			default: cmp.supply_above_off <= !v;
		endcase
	endtask : set_fault
	task report_and_stop;
		if (mismatches == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		report_and_stop();
	end
	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cmp} = '0;
		{short_diode, no_demag, mismatches, comparisons} = '0;
		repeat (5) @(posedge pclk);
		check("rst_sink", driver_sink, 1);
		check("rst_ramp", ramp_steep_x4, 0);
		check("rst_off", {off_mode, loop_ctrl_ground, on_time_ground, gate_drive}, 4'hE);
		presetn <= 1'b1;
		apb(0, `PFCS_CTRL_OFS, 0);
		check("ctrl_rst", rd, `PFCS_CTRL_RST);
		apb(0, 12'h0F0, 0);
		check("unmapped", err, 1);
		apb(1, `PFCS_STATUS_OFS, 32'hFF);
		check("status_wr", err, 0);
		// enable needs line and supply together
		{cmp.line_bo_start, cmp.line_bo_stop, cmp.supply_above_off, cmp.line_ll_sel} <= 4'hF;
		repeat (12) @(posedge pclk);
		check("en_nosup", {off_mode, gate_drive}, 2'b10);
		cmp.supply_on <= 1'b1;
		repeat (12) @(posedge pclk);
		check("en_on", {off_mode, driver_sink}, 2'b00);
		// pulses: demag restart, watchdog restart, overstress
		wait_lvl(gate_drive, 1);
		wait_lvl(gate_drive, 0);
		wait_lvl(gate_drive, 1);
		check("demag_rst", n < WDG, 1);
		no_demag <= 1'b1;
		wait_lvl(gate_drive, 0);
		wait_lvl(gate_drive, 1);
		check("wdog", n >= WDG && n <= WDG + 8, 1);
		no_demag <= 1'b0;
		short_diode <= 1'b1;
		wait_lvl(overstress_flag, 1);
		check("os_gate", {overstress_flag, gate_drive}, 2'b10);
		short_diode <= 1'b0;
		wait_lvl(overstress_flag, 0);
		check("os_len", n, OST);
		// line range: short excursion, entry, timer reset, drop, valley block
		cmp.line_hl_sel <= 1'b1;
		repeat (6) @(posedge pclk);
		cmp.line_hl_sel <= 1'b0;
		repeat (20) @(posedge pclk);
		check("hl_short", ramp_steep_x4, 0);
		cmp.line_hl_sel <= 1'b1;
		repeat (LH + 10) @(posedge pclk);
		check("hl_on", ramp_steep_x4, 1);
		apb(0, `PFCS_STATUS_OFS, 0);
		check("hl_stat", rd[`PFCS_ST_HILINE], 1);
		for (i = 0; i < 3; i++) begin
			cmp.line_ll_sel <= i[0];
			repeat (i[0] ? 8 : 25) @(posedge pclk);
		end
		check("hl_tmr", ramp_steep_x4, 1);
		repeat (25) @(posedge pclk);
		check("hl_drop", ramp_steep_x4, 0);
		cmp.line_ll_sel <= 1'b1;
		repeat (30) @(posedge pclk);
		apb(0, `PFCS_STATUS_OFS, 0);
		check("blk_set", {rd[`PFCS_ST_BLOCK], ramp_steep_x4}, 2'b10);
		for (i = 0; i < 8; i++) begin
			if (i == 7) check("blk_7", ramp_steep_x4, 0);
			cmp.valley <= 1'b1;
			repeat (5) @(posedge pclk);
			cmp.valley <= 1'b0;
			repeat (5) @(posedge pclk);
		end
		repeat (LH + 10) @(posedge pclk);
		check("blk_clr", ramp_steep_x4, 1);
		// brownout: two dropouts below expiry, then a long one
		for (i = 0; i < 2; i++) begin
			{cmp.line_bo_start, cmp.line_bo_stop} <= 2'b00;
			repeat (30) @(posedge pclk);
			{cmp.line_bo_start, cmp.line_bo_stop} <= 2'b11;
			repeat (8) @(posedge pclk);
		end
		check("bo_rstrt", off_mode, 0);
		{cmp.line_bo_start, cmp.line_bo_stop} <= 2'b00;
		repeat (BO + 10) @(posedge pclk);
		check("bo_off", {off_mode, driver_sink, gate_drive}, 3'b110);
		apb(0, `PFCS_STATUS_OFS, 0);
		check("bo_stat", rd[`PFCS_ST_BROWNOUT], 1);
		{cmp.line_bo_start, cmp.line_bo_stop} <= 2'b11;
		repeat (12) @(posedge pclk);
		check("bo_back", off_mode, 0);
		// run bit forces off mode
		apb(1, `PFCS_CTRL_OFS, 0);
		repeat (3) @(posedge pclk);
		check("run_off", {off_mode, gate_drive}, 2'b10);
		apb(1, `PFCS_CTRL_OFS, 1);
		repeat (5) @(posedge pclk);
		check("run_on", off_mode, 0);
		// regulation good and every fault
		cmp.reg_reached <= 1'b1;
		repeat (10) @(posedge pclk);
		check("pg_set", regulation_good_out, 1);
		cmp.reg_reached <= 1'b0;
		repeat (10) @(posedge pclk);
		check("pg_hold", regulation_good_out, 1);
		cmp.reg_reached <= 1'b1;
		for (i = 0; i < 9; i++) begin
			// regulation good must be back up, or the low check below proves nothing
			check("flt_pre", regulation_good_out, 1);
			set_fault(i, 1'b1);
			repeat (10) @(posedge pclk);
			check("flt_pg", regulation_good_out, 0);
			check("flt_off", off_mode, i == 0 || i > 4);
			if (i == 0 || i > 4) check("flt_gnd", {driver_sink, loop_ctrl_ground, on_time_ground, gate_drive}, 4'hE);
			if (i == 8) check("flt_chg", supply_charge_en, 1);
			set_fault(i, 1'b0);
			repeat (12) @(posedge pclk);
		end
		// supply back above turn-on: start-up source must let go
		check("chg_off", supply_charge_en, 0);
		report_and_stop();
	end
endmodule : tb_top
